// ===== hdl/aco_pkg.sv
package aco_pkg;
  // Word and input widths
  localparam int CODE_W = 14;
  localparam int IN_W = 16;
  // System clock 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  // No rising edge for this long means the clock has stopped
  localparam int STOP_TIME_NS = 1000;
  localparam int STOP_CYC = STOP_TIME_NS / CLK_PERIOD_NS;
  // Least power-down pulse that restarts the stabilizer
  localparam int PD_PULSE_NS = 1000;
  localparam int PD_CYC = (PD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELOCK_EDGES = 100;
  localparam int PIPE_LAT = 5;
  // Full-scale limits in output code steps of the selected range
  localparam int FS_POS = 8191;
  localparam int FS_NEG = -8192;
  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  // Status and enable bit positions
  localparam int IRQ_W = 3;
  localparam int EV_OVR = 0;
  localparam int EV_LOCK = 1;
  localparam int EV_LOST = 2;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
  // Synchronised pin vector positions
  localparam int PIN_W = 6;
  localparam int PIN_CONV = 5;
  localparam int PIN_PD = 4;
  localparam int PIN_OEN = 3;
  localparam int PIN_RNG = 2;
  localparam int PIN_MODE = 0;
  localparam logic [PIN_W-1:0] PIN_RST = 6'h08;

  typedef enum logic [1:0] {
    MODE_GND = 2'b00,
    MODE_THIRD = 2'b01,
    MODE_TWO_THIRDS = 2'b10,
    MODE_SUPPLY = 2'b11
  } aco_mode_e;

  typedef enum logic [1:0] {
    LK_STOPPED = 2'b00,
    LK_RELOCK = 2'b01,
    LK_LOCKED = 2'b10
  } aco_lock_e;

  typedef struct packed {
    logic unrel;
    logic ovr;
    logic [CODE_W-1:0] code;
  } aco_word_s;

  typedef struct packed {
    logic oe;
    logic pd;
    logic rng_1v;
    logic twos;
    logic dcs_on;
    aco_lock_e lock;
  } aco_state_s;
endpackage

// ===== hdl/aco_core.sv
// Overview of operation
// R01: Conversion clock never exceeds 25 Msps.
// R02: Conversion clock stays at or above 1 Msps.
// R03: Without stabilizer, clock duty cycle is 50 percent within 5 percent.
// R04: Each clock half period lasts at least 18.9 ns.
// R05: With stabilizer, sample on rising edge; falling edge made internally.
// R06: After clock stop, one hundred edges to relock; samples flagged unreliable.
// R07: Board straps mode pin at one or two thirds to enable stabilizer.
// R08: With stabilizer, a power-down pulse over 1 us after power-up.
// R09: 14-bit offset binary or two's complement, top bit inverted.
// R10: Over-range flag set beyond full scale; code clamped to full scale.
// R11: Range pin tied to supply for 2V, common mode for 1V. Here range_1v high selects the 1V range.
// R12: Range pin should be strapped, not driven from logic.
// R13: Sample appears five conversion edges after its capturing edge.
// R14: Mode strap picks format; stabilizer only on the middle levels.
// R15: Output-disable high turns off all data outputs and the flag.
// R16: Capture logic registers code and flag together on one edge.
`timescale 1ns/1ns
`default_nettype none
module aco_core #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Async reset
  input wire logic conv_clk_pin, // Conversion clock pin
  input wire logic power_down_strap, // Power-down pin
  input wire logic oe_n, // Output disable pin
  input wire logic range_1v, // High selects 1V range
  input wire logic [1:0] mode_level, // Mode strap level
  input wire logic signed [15:0] sample_in, // Input in 2V-range steps
  input wire logic [ADDR_W-1:0] reg_addr, // Register address
  input wire logic [DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [DATA_W-1:0] reg_rdata, // Read data
  output logic irq, // Interrupt level
  output logic [13:0] sample_code, // Output word
  output logic over_range_flag, // Over-range flag
  output logic dout_oe, // Drive enable, code and flag
  output logic sample_unreliable, // Word taken while unlocked
  output logic int_clk_phase // Internal clock phase
);

  localparam logic [7:0] STOP_C = 8'(aco_pkg::STOP_CYC);
  localparam logic [7:0] PD_C = 8'(aco_pkg::PD_CYC);
  localparam logic [6:0] RELOCK_C = 7'(aco_pkg::RELOCK_EDGES);

  function automatic aco_pkg::aco_word_s code_sample(
    input logic signed [15:0] v, input logic rng1v, input logic twos,
    input logic unrel);
    aco_pkg::aco_word_s w;
    logic signed [16:0] s;
    s = rng1v ? {v, 1'b0} : {v[15], v};
    w.unrel = unrel;
    w.ovr = 1'b0;
    w.code = s[13:0];
    if (s > 17'(aco_pkg::FS_POS)) begin
      w.ovr = 1'b1;
      w.code = 14'h1FFF;
    end else if (s < 17'(aco_pkg::FS_NEG)) begin
      w.ovr = 1'b1;
      w.code = 14'h2000;
    end
    if (!twos) begin
      w.code[13] = ~w.code[13];
    end
    return w;
  endfunction

  // Pin synchroniser, level taken once stages two and three agree
  logic [aco_pkg::PIN_W-1:0] sy1_r, sy2_r, sy3_r, pin_r, pin_nxt;
  logic conv_d_r;
  always_comb begin
    pin_nxt = (sy2_r & ~(sy2_r ^ sy3_r)) | (pin_r & (sy2_r ^ sy3_r));
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sy1_r <= aco_pkg::PIN_RST;
      sy2_r <= aco_pkg::PIN_RST;
      sy3_r <= aco_pkg::PIN_RST;
      pin_r <= aco_pkg::PIN_RST;
      conv_d_r <= 1'b0;
    end else begin
      sy1_r <= {conv_clk_pin, power_down_strap, oe_n, range_1v, mode_level};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      pin_r <= pin_nxt;
      conv_d_r <= pin_r[aco_pkg::PIN_CONV];
    end
  end

  logic conv_lvl, conv_edge, pd_lvl, dcs_on, fmt_twos;
  aco_pkg::aco_mode_e mode;
  assign conv_lvl = pin_r[aco_pkg::PIN_CONV];
  assign conv_edge = conv_lvl & ~conv_d_r;
  assign pd_lvl = pin_r[aco_pkg::PIN_PD];
  assign mode = aco_pkg::aco_mode_e'(pin_r[aco_pkg::PIN_MODE +: 2]);
  assign dcs_on = (mode == aco_pkg::MODE_THIRD) ||
                  (mode == aco_pkg::MODE_TWO_THIRDS); // R14
  assign fmt_twos = mode[1]; // R14

  // Stabilizer: lock tracking and internal falling edge
  aco_pkg::aco_lock_e lock_r, lock_nxt;
  logic [6:0] edge_cnt_r, edge_cnt_nxt;
  logic [7:0] idle_r, idle_nxt, per_r, per_nxt, pd_cnt_r, pd_cnt_nxt;
  logic pd_d_r, phase_r, phase_nxt, ev_lock, ev_lost;
  always_comb begin
    lock_nxt = lock_r;
    edge_cnt_nxt = edge_cnt_r;
    idle_nxt = (idle_r == STOP_C) ? idle_r : idle_r + 8'h01;
    per_nxt = per_r;
    pd_cnt_nxt = pd_lvl ? ((pd_cnt_r == PD_C) ? pd_cnt_r
                                              : pd_cnt_r + 8'h01) : 8'h00;
    phase_nxt = phase_r;
    ev_lock = 1'b0;
    ev_lost = 1'b0;
    if (conv_edge) begin
      idle_nxt = 8'h00;
      per_nxt = idle_r + 8'h01;
    end
    case (lock_r)
      aco_pkg::LK_STOPPED: begin
        if (conv_edge) begin
          lock_nxt = aco_pkg::LK_RELOCK;
          edge_cnt_nxt = 7'h00;
        end
      end
      aco_pkg::LK_RELOCK: begin
        if (conv_edge) begin
          edge_cnt_nxt = edge_cnt_r + 7'h01;
          if (edge_cnt_r == RELOCK_C - 7'h01) begin
            lock_nxt = aco_pkg::LK_LOCKED; // R06
            ev_lock = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
    if (!conv_edge && idle_r == STOP_C - 8'h01 &&
        lock_r != aco_pkg::LK_STOPPED) begin
      lock_nxt = aco_pkg::LK_STOPPED; // R06
      ev_lost = 1'b1;
    end
    if (pd_d_r && !pd_lvl && pd_cnt_r == PD_C) begin
      lock_nxt = aco_pkg::LK_STOPPED;
    end
    if (!dcs_on) begin
      phase_nxt = conv_lvl;
    end else if (conv_edge) begin
      phase_nxt = 1'b1; // R05
    end else if (idle_r + 8'h01 >= {1'b0, per_r[7:1]}) begin
      phase_nxt = 1'b0; // R05
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lock_r <= aco_pkg::LK_STOPPED;
      edge_cnt_r <= 7'h00;
      idle_r <= 8'h00;
      per_r <= 8'h00;
      pd_cnt_r <= 8'h00;
      pd_d_r <= 1'b0;
      phase_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      idle_r <= idle_nxt;
      per_r <= per_nxt;
      pd_cnt_r <= pd_cnt_nxt;
      pd_d_r <= pd_lvl;
      phase_r <= phase_nxt;
    end
  end

  // Conversion pipeline stepped by the conversion clock
  aco_pkg::aco_word_s pipe_r [0:aco_pkg::PIPE_LAT];
  aco_pkg::aco_word_s pipe_nxt [0:aco_pkg::PIPE_LAT];
  logic oe_r, oe_nxt;
  always_comb begin
    for (int i = 0; i <= aco_pkg::PIPE_LAT; i++) begin
      pipe_nxt[i] = pipe_r[i];
    end
    if (conv_edge) begin
      pipe_nxt[0] = code_sample(sample_in, pin_r[aco_pkg::PIN_RNG],
        fmt_twos, dcs_on && lock_r != aco_pkg::LK_LOCKED); // R09 R10 R06
      for (int i = 1; i <= aco_pkg::PIPE_LAT; i++) begin
        pipe_nxt[i] = pipe_r[i-1]; // R13
      end
    end
    oe_nxt = !pin_r[aco_pkg::PIN_OEN] && !pd_lvl; // R15
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i <= aco_pkg::PIPE_LAT; i++) begin
        pipe_r[i] <= '0;
      end
      oe_r <= 1'b0;
    end else begin
      pipe_r <= pipe_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign sample_code = pipe_r[aco_pkg::PIPE_LAT].code;
  assign over_range_flag = pipe_r[aco_pkg::PIPE_LAT].ovr;
  assign sample_unreliable = pipe_r[aco_pkg::PIPE_LAT].unrel;
  assign dout_oe = oe_r;
  assign int_clk_phase = phase_r;

  // Registers and interrupt
  logic [aco_pkg::IRQ_W-1:0] stat_r, stat_nxt, en_r, en_nxt, ev;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  aco_pkg::aco_state_s st;
  always_comb begin
    st = '{oe: oe_r, pd: pd_lvl, rng_1v: pin_r[aco_pkg::PIN_RNG],
           twos: fmt_twos, dcs_on: dcs_on, lock: lock_r};
    ev = '0;
    ev[aco_pkg::EV_OVR] = conv_edge && pipe_r[aco_pkg::PIPE_LAT-1].ovr;
    ev[aco_pkg::EV_LOCK] = ev_lock;
    ev[aco_pkg::EV_LOST] = ev_lost;
    stat_nxt = stat_r;
    en_nxt = en_r;
    rdata_nxt = '0;
    if (reg_wr && reg_addr == aco_pkg::ADDR_IRQ_CLR) begin
      stat_nxt = stat_r & ~reg_wdata[aco_pkg::IRQ_W-1:0];
    end else if (reg_wr && reg_addr == aco_pkg::ADDR_IRQ_EN) begin
      en_nxt = reg_wdata[aco_pkg::IRQ_W-1:0];
    end
    stat_nxt = stat_nxt | ev;
    if (reg_rd && reg_addr == aco_pkg::ADDR_STATUS) begin
      rdata_nxt = DATA_W'(stat_r);
    end else if (reg_rd && reg_addr == aco_pkg::ADDR_IRQ_EN) begin
      rdata_nxt = DATA_W'(en_r);
    end else if (reg_rd && reg_addr == aco_pkg::ADDR_STATE) begin
      rdata_nxt = DATA_W'(st);
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stat_r <= '0;
      en_r <= aco_pkg::IRQ_EN_RST;
      rdata_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;
  assign irq = |(stat_r & en_r);

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_pipe_latency: assert property (conv_edge |=> // R13
    pipe_r[aco_pkg::PIPE_LAT] == $past(pipe_r[aco_pkg::PIPE_LAT-1]))
    else $error("pipeline latency broken");
  a_out_step: assert property (!$stable(pipe_r[aco_pkg::PIPE_LAT]) // R13
    |-> $past(conv_edge))
    else $error("output word changed without a conversion edge");
  a_zero_code: assert property (conv_edge && sample_in == 16'h0000 // R09
    |=> pipe_r[0].code == ($past(fmt_twos) ? 14'h0000 : 14'h2000))
    else $error("zero input gave wrong code");
  a_ovr_cause: assert property (conv_edge && sample_in > 16'sh1FFF // R10
    |=> pipe_r[0].ovr && pipe_r[0].code[12:0] == 13'h1FFF)
    else $error("positive over-range not flagged or clamped");
  a_ovr_clamp: assert property (pipe_r[0].ovr // R10
    |-> pipe_r[0].code[12:0] == {13{pipe_r[0].code[12]}})
    else $error("over-range word not at full scale");
  a_oe_gate: assert property (pin_r[aco_pkg::PIN_OEN] |=> !dout_oe) // R15
    else $error("outputs driven while disabled");
  a_mode_decode: assert property ($past(mode) == aco_pkg::MODE_SUPPLY // R14
    |-> !$past(dcs_on) && $past(fmt_twos))
    else $error("mode strap decoded wrongly");
  a_relock_count: assert property (lock_r == aco_pkg::LK_LOCKED && // R06
    $past(lock_r) == aco_pkg::LK_RELOCK |->
    $past(edge_cnt_r) == RELOCK_C - 7'h01)
    else $error("lock declared before one hundred edges");
  a_unrel_mark: assert property (conv_edge && dcs_on && // R06
    lock_r != aco_pkg::LK_LOCKED |=> pipe_r[0].unrel)
    else $error("sample during relock not marked");
  a_int_rise: assert property (dcs_on && $past(dcs_on) && $rose(phase_r) // R05
    |-> $past(conv_edge))
    else $error("internal phase rose without input rising edge");

endmodule // aco_core
`default_nettype wire

// ===== verification/aco_capture.sv
`timescale 1ns/1ns
`default_nettype none
module aco_capture (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Async reset
  input wire logic [13:0] sample_code, // Word from converter
  input wire logic over_range_flag, // Flag from converter
  input wire logic sample_unreliable, // Relock marker
  input wire logic dout_oe, // Outputs driven
  output var aco_pkg::aco_word_s cap_word_r // Captured word
);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cap_word_r <= '0;
    end else if (dout_oe) begin
      cap_word_r <= {sample_unreliable, over_range_flag, sample_code};
    end
  end
endmodule // aco_capture
`default_nettype wire

// ===== verification/adc_clock_and_output_coding_test.sv
`timescale 1ns/1ns
`default_nettype none
module adc_clock_and_output_coding_test;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic oe_n = 1'b0;
  logic power_down_strap = 1'b0;
  logic range_1v = 1'b0;
  logic [1:0] mode_level = 2'b00;
  logic signed [15:0] sample_in = 16'h0000;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic conv_run = 1'b1;
  logic skew = 1'b0;
  wire logic conv_clk_pin;
  wire logic [7:0] reg_rdata;
  wire logic irq, over_range_flag, dout_oe, sample_unreliable, int_clk_phase;
  wire logic [13:0] sample_code;
  aco_pkg::aco_word_s cap;
  logic [7:0] d;
  int err_total = 0;
  int checked = 0;
  int vals[7] = '{0, 1, -1, 8191, -8192, 8192, -8193};

  aco_core uut (.clk_sys(clk_sys), .resetn(resetn),
    .conv_clk_pin(conv_clk_pin), .power_down_strap(power_down_strap),
    .oe_n(oe_n), .range_1v(range_1v), .mode_level(mode_level),
    .sample_in(sample_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .sample_code(sample_code), .over_range_flag(over_range_flag),
    .dout_oe(dout_oe), .sample_unreliable(sample_unreliable),
    .int_clk_phase(int_clk_phase));
  aco_capture cap_model (.clk_sys(clk_sys), .resetn(resetn),
    .sample_code(sample_code), .over_range_flag(over_range_flag),
    .sample_unreliable(sample_unreliable), .dout_oe(dout_oe),
    .cap_word_r(cap));

  always #20 clk_sys = ~clk_sys;
  // 16-cycle period, 50 percent duty, halts in place when stopped
  // Skew gives 75 percent high, used only with the stabilizer on
  always @(posedge clk_sys) if (conv_run) cnt <= cnt + 4'h1;
  assign conv_clk_pin = skew ? (cnt >= 4'h4) : cnt[3];

  function automatic logic [13:0] exp_code(int v, logic twos);
    logic [13:0] t;
    if (v > 8191) v = 8191;
    if (v < -8192) v = -8192;
    t = v[13:0];
    return twos ? t : (t ^ 14'h2000);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Returns 1 ns after the edge that drops the conversion pin
  task automatic wait_per(input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(posedge clk_sys);
        #1;
        t++;
      end while (cnt !== 4'h0 && t < 40);
      if (t >= 40) begin
        err_total++;
        summarize();
      end
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic test_regs();
    reg_read(aco_pkg::ADDR_IRQ_EN, d);
    chk("irq_en_reset", 16'h0000, 16'(d));
    reg_write(aco_pkg::ADDR_IRQ_EN, 8'h05);
    reg_read(aco_pkg::ADDR_IRQ_EN, d);
    chk("irq_en_rw", 16'h0005, 16'(d));
    reg_read(8'h10, d);
    chk("unmapped", 16'h0000, 16'(d));
    reg_read(aco_pkg::ADDR_IRQ_CLR, d);
    chk("clr_read", 16'h0000, 16'(d));
    reg_write(aco_pkg::ADDR_IRQ_EN, 8'h00);
    $display("test regs done");
  endtask

  task automatic test_coding();
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      mode_level <= 2'(m);
      for (int i = 0; i < 7; i++) begin
        @(posedge clk_sys);
        sample_in <= 16'(vals[i]);
        wait_per(8);
        chk("code", 16'(exp_code(vals[i], m[1])), 16'(cap.code));
        chk("flag", 16'(vals[i] > 8191 || vals[i] < -8192),
            16'(cap.ovr));
      end
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      range_1v <= 1'b1;
      sample_in <= (k == 0) ? 16'sh1004 : 16'sh07D0;
      wait_per(8);
      chk("code_1v", 16'(exp_code(k == 0 ? 8200 : 4000, 1'b1)),
          16'(cap.code));
      chk("flag_1v", 16'(k == 0), 16'(cap.ovr));
    end
    @(posedge clk_sys);
    range_1v <= 1'b0;
    sample_in <= 16'sh0000;
    reg_read(aco_pkg::ADDR_STATUS, d);
    chk("ovr_event", 16'h0001, 16'(d & 8'h01));
    reg_write(aco_pkg::ADDR_IRQ_EN, 8'h01);
    settle();
    chk("irq_on", 16'h0001, 16'(irq));
    reg_write(aco_pkg::ADDR_IRQ_CLR, 8'h07);
    settle();
    chk("irq_cleared", 16'h0000, 16'(irq));
    $display("test coding done");
  endtask

  task automatic test_latency();
    @(posedge clk_sys);
    mode_level <= 2'b00;
    wait_per(2);
    for (int k = 0; k < 12; k++) begin
      if (k >= 6) chk("latency", 16'(exp_code(100 * (k - 6), 1'b0)),
                      16'(sample_code));
      @(posedge clk_sys);
      sample_in <= 16'(100 * k);
      wait_per(1);
    end
    $display("test latency done");
  endtask

  task automatic test_oe();
    @(posedge clk_sys);
    oe_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chk("oe_off", 16'h0000, 16'(dout_oe));
    @(posedge clk_sys);
    oe_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk("oe_on", 16'h0001, 16'(dout_oe));
    $display("test oe done");
  endtask

  task automatic test_dcs();
    int hi;
    reg_write(aco_pkg::ADDR_IRQ_EN, 8'h06);
    @(posedge clk_sys);
    mode_level <= 2'b01;
    conv_run <= 1'b0;
    power_down_strap <= 1'b1;
    repeat (30) @(posedge clk_sys);
    #1 chk("pd_oe", 16'h0000, 16'(dout_oe));
    @(posedge clk_sys);
    power_down_strap <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reg_write(aco_pkg::ADDR_IRQ_CLR, 8'h07);
    reg_read(aco_pkg::ADDR_STATE, d);
    chk("state_stop", 16'h0044, 16'(d));
    conv_run <= 1'b1;
    wait_per(8);
    chk("unrel", 16'h0001, 16'(sample_unreliable));
    reg_read(aco_pkg::ADDR_STATE, d);
    chk("state_relock", 16'h0045, 16'(d));
    wait_per(104);
    reg_read(aco_pkg::ADDR_STATE, d);
    chk("state_lock", 16'h0046, 16'(d));
    chk("rel", 16'h0000, 16'(sample_unreliable));
    chk("irq_lock", 16'h0001, 16'(irq));
    reg_write(aco_pkg::ADDR_IRQ_CLR, 8'h02);
    settle();
    chk("irq_clr", 16'h0000, 16'(irq));
    wait_per(1);
    @(posedge clk_sys);
    skew <= 1'b1;
    wait_per(3);
    hi = 0;
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      #1 hi += int_clk_phase;
    end
    chk("phase_duty", 16'h0008, 16'(hi));
    wait_per(1);
    @(posedge clk_sys);
    skew <= 1'b0;
    conv_run <= 1'b0;
    repeat (40) @(posedge clk_sys);
    reg_read(aco_pkg::ADDR_STATUS, d);
    chk("lost", 16'h0004, 16'(d & 8'h04));
    chk("irq_lost", 16'h0001, 16'(irq));
    reg_write(aco_pkg::ADDR_IRQ_EN, 8'h00);
    settle();
    chk("irq_mask", 16'h0000, 16'(irq));
    $display("test dcs done");
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    test_regs();
    test_coding();
    test_latency();
    test_oe();
    test_dcs();
    summarize();
  end
endmodule // adc_clock_and_output_coding_test
`default_nettype wire
